// ==== hw/gpio_port_regs.svh ====
// register offsets, field positions, reset values for one gpio port
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// data window covers byte offsets 0x000..0x3fc, mask in addr[9:2]
`define DATA_WIN_LO      12'h000
`define DATA_WIN_HI      12'h3fc
`define MASK_LSB         2
`define MASK_MSB         9
`define DIR_OFFSET       12'h400
`define AFSEL_OFFSET     12'h420
`define PUR_OFFSET       12'h510
`define PDR_OFFSET       12'h514
`define DEN_OFFSET       12'h51c
`define LOCK_OFFSET      12'h520
`define COMMIT_OFFSET    12'h524
`define PIN_IN_OFFSET    12'h528
`define UNLOCK_KEY       32'h1acce551
`define RST_ZERO         8'h00
`define RST_DEBUG_MASK   8'h00
`define RST_COMMIT       8'hff

`endif

// ==== hw/gpio_port_pkg.sv ====
// types shared by the gpio port modules
package gpio_port_pkg;
    typedef logic [7:0]  pin_vec_t;
    typedef logic [11:0] addr_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        LOCKED   = 2'b01,
        UNLOCKED = 2'b10
    } lock_state_e;
endpackage : gpio_port_pkg

// ==== hw/gpio_pad_if.sv ====
// per-port pad control bundle between the port core and its pad stage
`timescale 1ns/1ps
`default_nettype none
interface gpio_pad_if;
    gpio_port_pkg::pin_vec_t dir;
    gpio_port_pkg::pin_vec_t data;
    gpio_port_pkg::pin_vec_t afsel;
    gpio_port_pkg::pin_vec_t den;
    gpio_port_pkg::pin_vec_t periph_out;
    gpio_port_pkg::pin_vec_t periph_oe;
    gpio_port_pkg::pin_vec_t pad_out;
    gpio_port_pkg::pin_vec_t pad_oe_n;
    modport core (output dir, data, afsel, den, input pad_out, pad_oe_n);
    modport pad  (input dir, data, afsel, den, periph_out, periph_oe,
                  output pad_out, pad_oe_n);
    modport top  (output periph_out, periph_oe);
endinterface : gpio_pad_if
`default_nettype wire

// ==== hw/gpio_pad_mux.sv ====
// pad stage: selects software or peripheral drive for each pin
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_mux (
    gpio_pad_if.pad pads
);
    // afsel hands the pin to the peripheral, else dir/data drive it
    assign pads.pad_out  = (pads.afsel & pads.periph_out) |
                           (~pads.afsel & pads.data); // RQ12
    // enable is active low; no pad driven without digital enable
    assign pads.pad_oe_n = ~(pads.den & ((pads.afsel & pads.periph_oe) |
                           (~pads.afsel & pads.dir))); // RQ7
endmodule : gpio_pad_mux
`default_nettype wire

// ==== hw/gpio_port.sv ====
// one general purpose i/o port of eight pins with masked data access
//
// Contract
// RQ1: ordinary pins reset undriven, config bits zero
// RQ2: debug pins reset afsel, den, pull-up one
// RQ3: any reset restores both pin groups' defaults
// RQ4: board must not hold debug reset pin low
// RQ5: eight ports built from this one block
// RQ6: direction zero: data bit captures pin value
// RQ7: direction one: data bit drives the pad
// RQ8: address bits 9..2 mask data accesses
// RQ9: data register answers at 256 word locations
// RQ10: masked write updates only selected bits
// RQ11: masked read returns zero for unselected bits
// RQ12: afsel gives pin to peripheral, else software
// RQ13: protected afsel bits need unlock and commit
// RQ14: eight-bit registers, upper bus bits zero
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.svh"
module gpio_port #(
    // debug pins of this port instance; zero on ordinary ports
    parameter logic [7:0] DEBUG_MASK = `RST_DEBUG_MASK // RQ5
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_n,
    input  wire logic [7:0]  periph_out,
    input  wire logic [7:0]  periph_oe,
    output logic      [7:0]  periph_in,
    output logic      [7:0]  pull_up_enable,
    output logic      [7:0]  pull_down_enable
);
    gpio_pad_if pads ();

    gpio_port_pkg::pin_vec_t pin_data_r;
    gpio_port_pkg::pin_vec_t pin_data_nxt;
    gpio_port_pkg::pin_vec_t pin_direction_r;
    gpio_port_pkg::pin_vec_t alt_function_select_r;
    gpio_port_pkg::pin_vec_t alt_function_select_nxt;
    gpio_port_pkg::pin_vec_t digital_pad_enable_r;
    gpio_port_pkg::pin_vec_t pull_up_enable_r;
    gpio_port_pkg::pin_vec_t pull_down_enable_r;
    gpio_port_pkg::pin_vec_t config_commit_r;
    gpio_port_pkg::lock_state_e lock_r;
    gpio_port_pkg::lock_state_e lock_nxt;
    gpio_port_pkg::word_t rdata_r;

    wire logic [7:0] mask     = addr[`MASK_MSB:`MASK_LSB]; // RQ8
    wire logic [7:0] wbyte    = wdata[7:0]; // RQ14
    wire logic       sel_data = addr <= `DATA_WIN_HI; // RQ9
    wire logic       sel_dir  = addr == `DIR_OFFSET;
    wire logic       sel_afs  = addr == `AFSEL_OFFSET;
    wire logic       sel_pur  = addr == `PUR_OFFSET;
    wire logic       sel_pdr  = addr == `PDR_OFFSET;
    wire logic       sel_den  = addr == `DEN_OFFSET;
    wire logic       sel_lock = addr == `LOCK_OFFSET;
    wire logic       sel_cr   = addr == `COMMIT_OFFSET;
    wire logic       sel_pin  = addr == `PIN_IN_OFFSET;
    wire logic       unlocked = lock_r == gpio_port_pkg::UNLOCKED;

    // input pins are captured continuously; output pins keep written value
    wire logic [7:0] data_wr  = (wr && sel_data) ? mask : 8'h00;
    assign pin_data_nxt = (~pin_direction_r & pin_in) |
                          (pin_direction_r & data_wr & wbyte) |
                          (pin_direction_r & ~data_wr & pin_data_r); // RQ6 RQ10

    // debug afsel bits only change when unlocked and committed
    wire logic [7:0] afs_open = ~DEBUG_MASK |
                                (unlocked ? config_commit_r : 8'h00);
    assign alt_function_select_nxt =
        (afs_open & wbyte) | (~afs_open & alt_function_select_r); // RQ13

    // any write to lock relocks unless it carries the key
    assign lock_nxt = (wdata == `UNLOCK_KEY) ? gpio_port_pkg::UNLOCKED
                                             : gpio_port_pkg::LOCKED;

    wire logic [7:0] rd_byte =
        sel_data ? (pin_data_r & mask) : // RQ11
        sel_dir  ? pin_direction_r :
        sel_afs  ? alt_function_select_r :
        sel_pur  ? pull_up_enable_r :
        sel_pdr  ? pull_down_enable_r :
        sel_den  ? digital_pad_enable_r :
        sel_cr   ? config_commit_r :
        sel_pin  ? pin_in : 8'h00;
    wire logic [31:0] rd_word =
        sel_lock ? {31'h0, ~unlocked} : {24'h000000, rd_byte}; // RQ14

    // async reset covers power-on and external reset pin alike
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_data_r            <= `RST_ZERO;
            pin_direction_r       <= `RST_ZERO;
            alt_function_select_r <= DEBUG_MASK; // RQ1 RQ2 RQ3
            digital_pad_enable_r  <= DEBUG_MASK; // RQ1 RQ2 RQ3
            pull_up_enable_r      <= DEBUG_MASK; // RQ1 RQ2 RQ3
            pull_down_enable_r    <= `RST_ZERO; // RQ1 RQ3
            config_commit_r       <= `RST_COMMIT;
            lock_r                <= gpio_port_pkg::LOCKED;
        end else begin
            pin_data_r <= pin_data_nxt;
            if (wr && sel_dir)
                pin_direction_r <= wbyte;
            if (wr && sel_afs)
                alt_function_select_r <= alt_function_select_nxt;
            if (wr && sel_den)
                digital_pad_enable_r <= wbyte;
            if (wr && sel_pur)
                pull_up_enable_r <= wbyte;
            if (wr && sel_pdr)
                pull_down_enable_r <= wbyte;
            if (wr && sel_cr && unlocked)
                config_commit_r <= wbyte;
            if (wr && sel_lock)
                lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rd ? rd_word : 32'h00000000;
    end

    assign rdata = rdata_r;

    assign pads.dir        = pin_direction_r;
    assign pads.data       = pin_data_r;
    assign pads.afsel      = alt_function_select_r;
    assign pads.den        = digital_pad_enable_r;
    assign pads.periph_out = periph_out;
    assign pads.periph_oe  = periph_oe;

    gpio_pad_mux u_pad (
        .pads (pads)
    );

    assign pin_out          = pads.pad_out;
    assign pin_oe_n         = pads.pad_oe_n;
    // peripherals see the pad only when the digital input is enabled
    assign periph_in        = pin_in & digital_pad_enable_r;
    assign pull_up_enable   = pull_up_enable_r;
    assign pull_down_enable = pull_down_enable_r;
endmodule : gpio_port
`default_nettype wire

// ==== dv/gpio_board_model.sv ====
// board side of the port pins: pad drive or board level per pin
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model (
    input  wire logic       rstn,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] board_val,
    output logic      [7:0] pin_in
);
    logic [7:0] ext;
    // debug reset pin kept high during reset, else the debug link drops
    assign ext = rstn ? board_val : (board_val | 8'h80);
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule : gpio_board_model
`default_nettype wire

// ==== dv/gpio_port_checker.sv ====
// concurrent checks on the gpio port read data and pins
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker #(
    parameter logic [7:0] DEBUG_MASK = 8'h00
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [11:0] addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic [7:0]  periph_oe,
    input wire logic [7:0]  periph_out,
    input wire logic [7:0]  pull_up_enable,
    input wire logic [7:0]  pull_down_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence data_rd; rd && addr[11:10] == 2'b00; endsequence
    sequence data_wr; wr && addr[11:10] == 2'b00; endsequence
    rd_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    upper_zero_a: assert property (rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    rd_mask_a: assert property (data_rd |=>
        (rdata[7:0] & ~$past(addr[9:2])) == 8'h0)
        else $error("unselected data bit read as one");
    rd_unmapped_a: assert property (rd && addr == 12'hffc |=> rdata == 0)
        else $error("unmapped read not zero");
    wr_keep_a: assert property (data_wr ##1 $stable(periph_out) |->
        ((pin_out ^ $past(pin_out)) & ~pin_oe_n & ~$past(pin_oe_n)
        & ~$past(addr[9:2])) == 8'h0)
        else $error("masked write changed an unselected pin");
    reset_pull_a: assert property ($rose(rstn) |->
        pull_up_enable == DEBUG_MASK && pull_down_enable == 8'h0)
        else $error("pull enables wrong after reset");
    reset_oe_a: assert property ($rose(rstn) |->
        pin_oe_n == ~(DEBUG_MASK & periph_oe))
        else $error("pin drive enables wrong after reset");
    oe_hold_a: assert property (!$past(wr) && $stable(periph_oe) |->
        $stable(pin_oe_n))
        else $error("pin drive enable changed without cause");
endmodule : gpio_port_checker
`default_nettype wire

// ==== dv/gpio_port_data_direction_tb.sv ====
// self-checking bench for two gpio ports set up as port b and port c
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.svh"
module gpio_port_data_direction_tb;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pull_up_enable, pull_down_enable;
    logic [7:0]  periph_in, pull_up_c;
    logic [7:0]  periph_out = 8'h0, periph_oe = 8'h0, board_val = 8'h5a;
    int          failures = 0, total_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    gpio_port #(.DEBUG_MASK(8'h80)) dut (.clk(clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in),
        .pull_up_enable(pull_up_enable), .pull_down_enable(pull_down_enable));
    // second port with four debug pins, sharing bus and pins with port b
    gpio_port #(.DEBUG_MASK(8'h0f)) dut_c (.clk(clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
        .pin_in(pin_in), .pin_out(), .pin_oe_n(),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(),
        .pull_up_enable(pull_up_c), .pull_down_enable());
    gpio_board_model board (.rstn(rstn), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .board_val(board_val), .pin_in(pin_in));
    task complete_run;
        $display("failures=%0d total_checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk
    task do_reset;
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset
    task reset_defaults;
        #1 check(32'(pull_up_enable), 32'h80);
        check(32'(pull_down_enable), 32'h0);
        check(32'(pin_oe_n), 32'hff);
        check(32'(pull_up_c), 32'h0f);
        rd_chk(`AFSEL_OFFSET, 32'h80);
        rd_chk(`DEN_OFFSET, 32'h80);
    endtask : reset_defaults
    task masked_write;
        bus_wr(`DEN_OFFSET, 32'hff);
        bus_wr(`DIR_OFFSET, 32'hff);
        bus_wr(12'h3fc, 32'hff);
        bus_wr(12'h098, 32'hffffffeb);
        #1 check(32'(pin_out & 8'h7f), 32'h7b);
        check(32'(pin_oe_n), 32'h80);
        rd_chk(12'h0c4, 32'h31);
        rd_chk(12'h000, 32'h0);
        rd_chk(12'h3fc, 32'hfb);
        rd_chk(12'hffc, 32'h0);
    endtask : masked_write
    task input_capture;
        bus_wr(`DIR_OFFSET, 32'h00);
        board_val <= 8'ha5;
        repeat (2) @(posedge clk);
        rd_chk(12'h1fc, 32'h25);
        check(32'(periph_in), 32'ha5);
    endtask : input_capture
    task commit_lock;
        @(posedge clk);
        periph_out <= 8'h80;
        periph_oe <= 8'h80;
        @(posedge clk);
        #1 check(32'(pin_oe_n & 8'h80), 32'h0);
        check(32'(pin_out & 8'h80), 32'h80);
        bus_wr(`AFSEL_OFFSET, 32'h0);
        rd_chk(`AFSEL_OFFSET, 32'h80);
        bus_wr(`LOCK_OFFSET, `UNLOCK_KEY);
        bus_wr(`AFSEL_OFFSET, 32'h0);
        rd_chk(`AFSEL_OFFSET, 32'h0);
        #1 check(32'(pin_oe_n & 8'h80), 32'h80);
        @(posedge clk);
        periph_oe <= 8'h00;
    endtask : commit_lock
    task pad_config;
        bus_wr(`PUR_OFFSET, 32'hffffff12);
        #1 check(32'(pull_up_enable), 32'h12);
        bus_wr(`PDR_OFFSET, 32'h34);
        #1 check(32'(pull_down_enable), 32'h34);
        rd_chk(`LOCK_OFFSET, 32'h0);
        bus_wr(`COMMIT_OFFSET, 32'h0);
        bus_wr(`AFSEL_OFFSET, 32'hff);
        rd_chk(`AFSEL_OFFSET, 32'h7f);
        bus_wr(`LOCK_OFFSET, 32'h0);
        bus_wr(`COMMIT_OFFSET, 32'hff);
        rd_chk(`COMMIT_OFFSET, 32'h0);
        rd_chk(`LOCK_OFFSET, 32'h1);
        rd_chk(`PIN_IN_OFFSET, 32'ha5);
    endtask : pad_config
    initial begin
        do_reset();
        reset_defaults();
        masked_write();
        input_capture();
        commit_lock();
        pad_config();
        @(posedge clk);
        do_reset();
        reset_defaults();
        complete_run();
    end
endmodule : gpio_port_data_direction_tb
bind gpio_port gpio_port_checker #(.DEBUG_MASK(DEBUG_MASK)) chk (.clk(clk),
    .rstn(rstn), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_oe(periph_oe),
    .periph_out(periph_out), .pull_up_enable(pull_up_enable),
    .pull_down_enable(pull_down_enable));
`default_nettype wire
